// File: slt_pkg.sv
// Purpose: shared constants and types for the short-threshold register slice
// Assumes: 8-bit register space, byte-wide data
// Notes:   select registers carry two 3-bit groups each
`default_nettype none
package slt_pkg;

	localparam int ADDR_W       = 8;
	localparam int DATA_W       = 8;
	localparam int CODE_W       = 8;
	localparam int NUM_GROUPS   = 6;
	localparam int CH_PER_GROUP = 3;
	localparam int NUM_CH       = NUM_GROUPS * CH_PER_GROUP;
	localparam int NUM_SEL      = 3;
	localparam int GROUP_LO_LSB = 0;
	localparam int GROUP_HI_LSB = 4;
	localparam int ENABLE_BIT   = 7;

	localparam logic [ADDR_W-1:0] ADDR_SEL_CD      = 8'h75;
	localparam logic [ADDR_W-1:0] ADDR_SEL_EF      = 8'h76;
	localparam logic [ADDR_W-1:0] ADDR_SEL_GH      = 8'h77;
	localparam logic [ADDR_W-1:0] ADDR_CODE_FIRST  = 8'h78;
	localparam logic [ADDR_W-1:0] ADDR_CODE_SECOND = 8'h79;
	localparam logic [ADDR_W-1:0] ADDR_DIAG_CTRL   = 8'h7a;

	localparam logic [1:0] SEL_IDX_CD = 2'h0;
	localparam logic [1:0] SEL_IDX_EF = 2'h1;
	localparam logic [1:0] SEL_IDX_GH = 2'h2;

	// writable bits of a select register; bits 7 and 3 stay zero
	localparam logic [DATA_W-1:0] SEL_MASK   = 8'h77;
	localparam logic [DATA_W-1:0] ZERO_BYTE  = 8'h00;
	localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;

	// comparison voltage = code * step + base
	localparam int THRESH_STEP_UV = 125000;
	localparam int THRESH_BASE_UV = 2500000;

	typedef struct packed {
		logic [DATA_W-1:0] sel_cd;
		logic [DATA_W-1:0] sel_ef;
		logic [DATA_W-1:0] sel_gh;
		logic [CODE_W-1:0] code_first;
		logic [CODE_W-1:0] code_second;
		logic              diag_enable;
	} slt_nvm_s;

	typedef enum logic [1:0] {
		SLT_WAIT = 2'b00,
		SLT_LOAD = 2'b01,
		SLT_DONE = 2'b10
	} slt_load_e;

endpackage : slt_pkg
`default_nettype wire

// File: slt_nvm_load.sv
// Purpose: one load pulse from the nonvolatile image after reset
// Assumes: i_valid comes from logic on the same clock
// Notes:   loads once per reset
`timescale 1ns/10ps
`default_nettype none
module slt_nvm_load (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_valid,
	output logic      o_load,
	output logic      o_done
);
	import slt_pkg::*;

	slt_load_e state;
	slt_load_e next_state;

	always_comb begin
		next_state = state;
		case (state)
			SLT_WAIT: begin
				if (i_valid) begin
					next_state = SLT_LOAD;
				end
			end
			SLT_LOAD: next_state = SLT_DONE;
			SLT_DONE: next_state = SLT_DONE;
			default:  next_state = SLT_WAIT;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= SLT_WAIT;
		end else begin
			state <= next_state;
		end
	end

	assign o_load = (state == SLT_LOAD);
	assign o_done = (state == SLT_DONE);

endmodule : slt_nvm_load
`default_nettype wire

// File: slt_chan_pick.sv
// Purpose: per-group threshold routing for three channels
// Assumes: inputs are the next register values
// Notes:   outputs change on the same edge as the registers
`timescale 1ns/10ps
`default_nettype none
module slt_chan_pick #(
	parameter int N = 3,
	parameter int W = 8
) (
	input  wire logic                i_clk,
	input  wire logic                i_rst_n,
	input  wire logic [N-1:0]        i_sel,
	input  wire logic [W-1:0]        i_code_first,
	input  wire logic [W-1:0]        i_code_second,
	input  wire logic                i_enable,
	output logic      [N-1:0][W-1:0] o_code,
	output logic      [N-1:0]        o_pick,
	output logic      [N-1:0]        o_run
);
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_code <= '0;
			o_pick <= '0;
			o_run  <= '0;
		end else begin
			for (int c = 0; c < N; c++) begin
				o_code[c] <= i_sel[c] ? i_code_second : i_code_first;
				o_pick[c] <= i_sel[c];
				o_run[c]  <= i_enable;
			end
		end
	end

endmodule : slt_chan_pick
`default_nettype wire

// File: slt_regs.sv
// Purpose: short-circuit threshold select and code registers, channel routing
// Assumes: single 20 MHz clock, plain strobe register port, image valid on i_clk
// Notes:   read data stand one cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Function
// R1: select bit 0 picks first code, 1 picks second code for its channel.
// R2: bits 7 and 3 of select registers read zero, ignore writes.
// R3: reset values of all fields come from the nonvolatile image.
// R4: first code is 8 bits at 78h; volts = code*0.125 + 2.5.
// R5: second code is 8 bits at 79h; volts = code*0.125 + 2.5.
// R6: 75h holds group D picks in bits 6..4, group C in 2..0.
// R7: 76h holds group F picks in bits 6..4, group E in 2..0.
// R8: 77h holds group H picks in bits 6..4, group G in 2..0.
// R9: bit 7 at 7Ah enables short diagnostics; 0 disables them.
// R10: each channel gets its chosen code one cycle after a write.
module slt_regs (
	input  wire logic                                       i_clk,
	input  wire logic                                       i_rst_n,
	input  wire logic [slt_pkg::ADDR_W-1:0]                 i_addr,
	input  wire logic [slt_pkg::DATA_W-1:0]                 i_wdata,
	input  wire logic                                       i_wr,
	input  wire logic                                       i_rd,
	input  wire logic                                       i_nvm_valid,
	input  wire slt_pkg::slt_nvm_s                          i_nvm_image,
	output logic      [slt_pkg::DATA_W-1:0]                 o_rdata,
	output logic                                            o_nvm_loaded,
	output logic                                            o_diag_enable,
	output logic      [slt_pkg::NUM_CH-1:0][slt_pkg::CODE_W-1:0] o_ch_code,
	output logic      [slt_pkg::NUM_CH-1:0]                 o_ch_pick,
	output logic      [slt_pkg::NUM_CH-1:0]                 o_ch_run
);
	import slt_pkg::*;

	logic [NUM_SEL-1:0][DATA_W-1:0] sel_reg;
	logic [NUM_SEL-1:0][DATA_W-1:0] next_sel;
	logic [CODE_W-1:0]              code_first;
	logic [CODE_W-1:0]              next_code_first;
	logic [CODE_W-1:0]              code_second;
	logic [CODE_W-1:0]              next_code_second;
	logic                           diag_en;
	logic                           next_diag_en;
	logic [DATA_W-1:0]              next_rdata;
	logic                           nvm_load;
	logic                           nvm_done;

	//////////////////////////////////////////////////////////////////////////
	// nonvolatile image load

	slt_nvm_load u_load (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_valid (i_nvm_valid),
		.o_load  (nvm_load),
		.o_done  (nvm_done)
	);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_nvm_loaded <= 1'b0;
		end else begin
			o_nvm_loaded <= nvm_done | nvm_load;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// register next values; image load wins over a write

	always_comb begin
		next_sel         = sel_reg;
		next_code_first  = code_first;
		next_code_second = code_second;
		next_diag_en     = diag_en;
		if (nvm_load) begin
			next_sel[SEL_IDX_CD] = i_nvm_image.sel_cd & SEL_MASK; // [R3] [R2]
			next_sel[SEL_IDX_EF] = i_nvm_image.sel_ef & SEL_MASK; // [R3] [R2]
			next_sel[SEL_IDX_GH] = i_nvm_image.sel_gh & SEL_MASK; // [R3] [R2]
			next_code_first      = i_nvm_image.code_first;        // [R3]
			next_code_second     = i_nvm_image.code_second;       // [R3]
			next_diag_en         = i_nvm_image.diag_enable;       // [R3]
		end else if (i_wr) begin
			case (i_addr)
				ADDR_SEL_CD:      next_sel[SEL_IDX_CD] = i_wdata & SEL_MASK; // [R6] [R2]
				ADDR_SEL_EF:      next_sel[SEL_IDX_EF] = i_wdata & SEL_MASK; // [R7] [R2]
				ADDR_SEL_GH:      next_sel[SEL_IDX_GH] = i_wdata & SEL_MASK; // [R8] [R2]
				ADDR_CODE_FIRST:  next_code_first  = i_wdata;               // [R4]
				ADDR_CODE_SECOND: next_code_second = i_wdata;               // [R5]
				ADDR_DIAG_CTRL:   next_diag_en     = i_wdata[ENABLE_BIT];   // [R9]
				default:          next_diag_en     = diag_en;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sel_reg <= '0;
		end else begin
			sel_reg <= next_sel;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			code_first  <= CODE_RESET;
			code_second <= CODE_RESET;
		end else begin
			code_first  <= next_code_first;
			code_second <= next_code_second;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			diag_en       <= 1'b0;
			o_diag_enable <= 1'b0;
		end else begin
			diag_en       <= next_diag_en;
			o_diag_enable <= next_diag_en; // [R9]
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// read port; unmapped addresses read zero

	always_comb begin
		next_rdata = ZERO_BYTE;
		case (i_addr)
			ADDR_SEL_CD:      next_rdata = sel_reg[SEL_IDX_CD] & SEL_MASK; // [R2]
			ADDR_SEL_EF:      next_rdata = sel_reg[SEL_IDX_EF] & SEL_MASK; // [R2]
			ADDR_SEL_GH:      next_rdata = sel_reg[SEL_IDX_GH] & SEL_MASK; // [R2]
			ADDR_CODE_FIRST:  next_rdata = code_first;
			ADDR_CODE_SECOND: next_rdata = code_second;
			ADDR_DIAG_CTRL:   next_rdata[ENABLE_BIT] = diag_en;
			default:          next_rdata = ZERO_BYTE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= ZERO_BYTE;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= ZERO_BYTE;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// per-group routing, groups C..H in channel order

	for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
		localparam int REG = g / 2;
		localparam int LSB = (g % 2 == 0) ? GROUP_LO_LSB : GROUP_HI_LSB;

		slt_chan_pick #(
			.N (CH_PER_GROUP),
			.W (CODE_W)
		) u_pick (
			.i_clk         (i_clk),
			.i_rst_n       (i_rst_n),
			.i_sel         (next_sel[REG][LSB +: CH_PER_GROUP]), // [R6] [R7] [R8]
			.i_code_first  (next_code_first),                    // [R1] [R10]
			.i_code_second (next_code_second),                   // [R1] [R10]
			.i_enable      (next_diag_en),                       // [R9]
			.o_code        (o_ch_code[g*CH_PER_GROUP +: CH_PER_GROUP]),
			.o_pick        (o_ch_pick[g*CH_PER_GROUP +: CH_PER_GROUP]),
			.o_run         (o_ch_run[g*CH_PER_GROUP +: CH_PER_GROUP])
		);
	end

	//////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	localparam int CH_C0 = 0;
	localparam int CH_D2 = 5;
	localparam int CH_E0 = 6;
	localparam int CH_F2 = 11;
	localparam int CH_G0 = 12;
	localparam int CH_H0 = 15;
	localparam int CH_H2 = 17;

	a_pick_first_code: assert property ( // [R1]
		!o_ch_pick[CH_C0] |-> o_ch_code[CH_C0] == code_first)
		else $error("channel with select 0 does not carry the first code");

	a_pick_second_code: assert property ( // [R1]
		o_ch_pick[CH_H2] |-> o_ch_code[CH_H2] == code_second)
		else $error("channel with select 1 does not carry the second code");

	a_sel_reserved_zero: assert property ( // [R2]
		(sel_reg[SEL_IDX_CD] & ~SEL_MASK) == ZERO_BYTE
		&& (sel_reg[SEL_IDX_EF] & ~SEL_MASK) == ZERO_BYTE
		&& (sel_reg[SEL_IDX_GH] & ~SEL_MASK) == ZERO_BYTE)
		else $error("reserved select bit became set");

	a_read_reserved_bits: assert property ( // [R2]
		i_rd && i_addr == ADDR_SEL_EF |=> !o_rdata[7] && !o_rdata[3])
		else $error("reserved select bits read nonzero");

	a_nvm_load_value: assert property ( // [R3]
		nvm_load |=> code_second == $past(i_nvm_image.code_second)
		&& diag_en == $past(i_nvm_image.diag_enable) && o_nvm_loaded)
		else $error("image load did not set the registers");

	a_first_code_write: assert property ( // [R4]
		i_wr && !nvm_load && i_addr == ADDR_CODE_FIRST
		|=> code_first == $past(i_wdata))
		else $error("first code write lost");

	a_second_code_read: assert property ( // [R5]
		i_rd && i_addr == ADDR_CODE_SECOND |=> o_rdata == $past(code_second))
		else $error("second code read returned wrong value");

	a_group_d_map: assert property ( // [R6]
		i_wr && !nvm_load && i_addr == ADDR_SEL_CD
		|=> o_ch_pick[CH_D2] == $past(i_wdata[6]))
		else $error("group D channel 2 select not at bit 6");

	a_group_f_map: assert property ( // [R7]
		i_wr && !nvm_load && i_addr == ADDR_SEL_EF
		|=> o_ch_pick[CH_F2] == $past(i_wdata[6]))
		else $error("group F channel 2 select not at bit 6");

	a_group_g_map: assert property ( // [R8]
		i_wr && !nvm_load && i_addr == ADDR_SEL_GH
		|=> o_ch_pick[CH_G0] == $past(i_wdata[0]))
		else $error("group G channel 0 select not at bit 0");

	a_enable_write: assert property ( // [R9]
		i_wr && !nvm_load && i_addr == ADDR_DIAG_CTRL
		|=> o_diag_enable == $past(i_wdata[ENABLE_BIT]) && o_ch_run[CH_H2] == o_diag_enable)
		else $error("diagnostic enable not taken from bit 7");

	a_route_next_cycle: assert property ( // [R10]
		i_wr && !nvm_load && i_addr == ADDR_CODE_SECOND
		|=> o_ch_code[CH_C0] == (o_ch_pick[CH_C0] ? $past(i_wdata) : code_first))
		else $error("channel code not updated one cycle after write");

	a_group_c_map: assert property ( // [R6]
		i_wr && !nvm_load && i_addr == ADDR_SEL_CD
		|=> o_ch_pick[CH_C0] == $past(i_wdata[GROUP_LO_LSB]))
		else $error("group C channel 0 select not at bit 0");

	a_group_e_map: assert property ( // [R7]
		i_wr && !nvm_load && i_addr == ADDR_SEL_EF
		|=> o_ch_pick[CH_E0] == $past(i_wdata[GROUP_LO_LSB]))
		else $error("group E channel 0 select not at bit 0");

	a_group_h_map: assert property ( // [R8]
		i_wr && !nvm_load && i_addr == ADDR_SEL_GH
		|=> o_ch_pick[CH_H0] == $past(i_wdata[GROUP_HI_LSB]))
		else $error("group H channel 0 select not at bit 4");

	a_second_code_write: assert property ( // [R5]
		i_wr && !nvm_load && i_addr == ADDR_CODE_SECOND
		|=> code_second == $past(i_wdata))
		else $error("second code write lost");

	a_first_code_read: assert property ( // [R4]
		i_rd && i_addr == ADDR_CODE_FIRST |=> o_rdata == $past(code_first))
		else $error("first code read returned wrong value");

	a_first_code_held: assert property ( // [R4]
		!i_wr && !nvm_load |=> code_first == $past(code_first))
		else $error("first code changed without a write");

	a_second_code_held: assert property ( // [R5]
		!i_wr && !nvm_load |=> code_second == $past(code_second))
		else $error("second code changed without a write");

	a_sel_cd_read: assert property ( // [R6]
		i_rd && i_addr == ADDR_SEL_CD |=> o_rdata == $past(sel_reg[SEL_IDX_CD]))
		else $error("group C and D select read returned wrong value");

	a_ctrl_read: assert property ( // [R9]
		i_rd && i_addr == ADDR_DIAG_CTRL |=> o_rdata[ENABLE_BIT] == $past(diag_en)
		&& o_rdata[ENABLE_BIT-1:0] == '0)
		else $error("enable register read returned wrong value");

	a_run_all_equal: assert property ( // [R9]
		o_ch_run == {NUM_CH{o_diag_enable}})
		else $error("channel run flags differ from the global enable");

	a_pick_tracks_reg: assert property ( // [R10]
		o_ch_pick[CH_G0] == sel_reg[SEL_IDX_GH][GROUP_LO_LSB])
		else $error("group G channel 0 pick lags its select register");

	a_load_once: assert property ( // [R3]
		o_nvm_loaded |-> !nvm_load)
		else $error("image loaded a second time");

	a_loaded_stays: assert property ( // [R3]
		o_nvm_loaded |=> o_nvm_loaded)
		else $error("loaded flag dropped without reset");

	c_nvm_load: cover property (nvm_load ##1 o_nvm_loaded);
	c_second_write: cover property (i_wr && i_addr == ADDR_CODE_SECOND ##1 o_ch_pick[CH_C0]);
	c_pick_second: cover property (i_wr && i_addr == ADDR_SEL_GH ##1 o_ch_pick[CH_H2]);
	c_enable_on: cover property (!o_diag_enable ##1 o_diag_enable);
	c_read_back: cover property (i_wr && i_addr == ADDR_CODE_FIRST ##1 i_rd
		&& i_addr == ADDR_CODE_FIRST);

endmodule : slt_regs
`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench for the short-threshold register slice
// Assumes: image handshake completes within a few cycles of i_nvm_valid
// Notes:   a reference model of the registers is kept in the bench
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import slt_pkg::*;
	logic                             i_clk = 1'b0;
	logic                             i_rst_n = 1'b0;
	logic [ADDR_W-1:0]                i_addr = 8'h00;
	logic [DATA_W-1:0]                i_wdata = 8'h00;
	logic                             i_wr = 1'b0;
	logic                             i_rd = 1'b0;
	logic                             i_nvm_valid = 1'b0;
	slt_nvm_s                         i_nvm_image = '0;
	logic [DATA_W-1:0]                o_rdata;
	logic                             o_nvm_loaded;
	logic                             o_diag_enable;
	logic [NUM_CH-1:0][CODE_W-1:0]    o_ch_code;
	logic [NUM_CH-1:0]                o_ch_pick;
	logic [NUM_CH-1:0]                o_ch_run;
	logic [DATA_W-1:0]                m_sel [NUM_SEL];
	logic [CODE_W-1:0]                m_c1, m_c2;
	logic                             m_en;
	int                               n_mismatch = 0;
	int                               check_count = 0;
	always #25 i_clk = ~i_clk;
	slt_regs slt_regs_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .i_nvm_valid(i_nvm_valid), .i_nvm_image(i_nvm_image),
		.o_rdata(o_rdata), .o_nvm_loaded(o_nvm_loaded), .o_diag_enable(o_diag_enable),
		.o_ch_code(o_ch_code), .o_ch_pick(o_ch_pick), .o_ch_run(o_ch_run));
	//////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk8
	// model write side: reserved bits masked, unmapped ignored
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
		case (a)
			ADDR_SEL_CD: m_sel[0] = d & 8'h77;
			ADDR_SEL_EF: m_sel[1] = d & 8'h77;
			ADDR_SEL_GH: m_sel[2] = d & 8'h77;
			ADDR_CODE_FIRST: m_c1 = d;
			ADDR_CODE_SECOND: m_c2 = d;
			ADDR_DIAG_CTRL: m_en = d[7];
			default: ;
		endcase
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd
	task automatic chk_ch();
		logic [NUM_CH-1:0][CODE_W-1:0] e_code;
		logic [NUM_CH-1:0]             e_pick;
		logic                          b;
		for (int g = 0; g < NUM_GROUPS; g++) begin
			for (int c = 0; c < CH_PER_GROUP; c++) begin
				b = m_sel[g/2][(g%2)*4+c];
				e_pick[g*3+c] = b;
				e_code[g*3+c] = b ? m_c2 : m_c1;
			end
		end
		check_count++;
		if (o_ch_code !== e_code || o_ch_pick !== e_pick) begin
			n_mismatch++;
			$display("mismatch ch_code expected %h seen %h", e_code, o_ch_code);
		end
		check_count++;
		if (o_ch_run !== {NUM_CH{m_en}} || o_diag_enable !== m_en) begin
			n_mismatch++;
			$display("mismatch ch_run expected %h seen %h", {NUM_CH{m_en}}, o_ch_run);
		end
	endtask : chk_ch
	task automatic chk_regs();
		logic [7:0] d;
		rd(ADDR_SEL_CD, d);
		chk8("sel_cd", m_sel[0], d);
		rd(ADDR_SEL_EF, d);
		chk8("sel_ef", m_sel[1], d);
		rd(ADDR_SEL_GH, d);
		chk8("sel_gh", m_sel[2], d);
		rd(ADDR_CODE_FIRST, d);
		chk8("code_first", m_c1, d);
		rd(ADDR_CODE_SECOND, d);
		chk8("code_second", m_c2, d);
		rd(ADDR_DIAG_CTRL, d);
		chk8("diag_ctrl", {m_en, 7'h00}, d);
		@(posedge i_clk);
		#1;
		chk8("rdata_idle", 8'h00, o_rdata);
		chk_ch();
	endtask : chk_regs
	//////////////////////////////////////////////////////////////////////////////
	// reset, then load an image; all fields must follow it
	task automatic t_reset_load(input slt_nvm_s img);
		int n;
		@(posedge i_clk);
		i_rst_n     <= 1'b0;
		i_nvm_valid <= 1'b0;
		i_nvm_image <= img;
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		i_nvm_valid <= 1'b1;
		n = 0;
		while (o_nvm_loaded !== 1'b1) begin
			@(posedge i_clk);
			#1;
			n++;
			if (n > 10) begin
				n_mismatch++;
				$display("mismatch nvm_loaded expected 1 seen %b", o_nvm_loaded);
				give_verdict();
			end
		end
		m_sel[0] = img.sel_cd & 8'h77;
		m_sel[1] = img.sel_ef & 8'h77;
		m_sel[2] = img.sel_gh & 8'h77;
		m_c1 = img.code_first;
		m_c2 = img.code_second;
		m_en = img.diag_enable;
		chk_regs();
	endtask : t_reset_load
	// all ones into the select registers, then only the reserved bits into EF
	task automatic t_sel_rsvd();
		for (int i = 0; i < NUM_SEL; i++) begin
			wr(ADDR_SEL_CD + 8'(i), 8'hff);
			chk_ch();
		end
		chk_regs();
		wr(ADDR_SEL_EF, 8'h88);
		chk_regs();
	endtask : t_sel_rsvd
	// boundary codes under a mixed select pattern, back-to-back writes
	task automatic t_codes();
		wr(ADDR_SEL_CD, 8'h41);
		wr(ADDR_SEL_EF, 8'h16);
		wr(ADDR_SEL_GH, 8'h64);
		wr(ADDR_CODE_FIRST, 8'h00);
		chk_ch();
		wr(ADDR_CODE_SECOND, 8'hff);
		chk_ch();
		wr(ADDR_CODE_FIRST, 8'ha5);
		wr(ADDR_CODE_SECOND, 8'h5a);
		chk_regs();
	endtask : t_codes
	// global enable off and on, low bits ignored
	task automatic t_enable();
		wr(ADDR_DIAG_CTRL, 8'h7f);
		chk_regs();
		wr(ADDR_DIAG_CTRL, 8'h80);
		chk_regs();
	endtask : t_enable
	// unmapped neighbours read zero and leave the model untouched
	task automatic t_unmapped();
		logic [7:0] d;
		wr(8'h74, 8'hff);
		wr(8'h7b, 8'hff);
		rd(8'h74, d);
		chk8("unmapped_74", 8'h00, d);
		rd(8'h7b, d);
		chk8("unmapped_7b", 8'h00, d);
		chk_regs();
	endtask : t_unmapped
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		t_reset_load('{8'hff, 8'h25, 8'h5a, 8'h3c, 8'hc3, 1'b1});
		t_sel_rsvd();
		t_codes();
		t_enable();
		t_unmapped();
		t_reset_load('{8'h88, 8'h70, 8'h07, 8'hff, 8'h00, 1'b0});
		t_codes();
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
